//--- afs_pkg.sv
package afs_pkg;
   // ==========================================================
   // Arc control limits and defaults
   localparam logic [3:0] ARC_CNT_MIN = 4'h2;
   localparam logic [3:0] ARC_CNT_MAX = 4'hA;
   localparam logic [3:0] ARC_CNT_DEF = 4'h4;
   localparam logic [4:0] ARC_PER_MIN_S = 5'h0A;
   localparam logic [4:0] ARC_PER_MAX_S = 5'h14;
   localparam logic [4:0] ARC_PER_DEF_S = 5'h0A;
   localparam logic [8:0] QUENCH_MIN_MS = 9'h032;
   localparam logic [8:0] QUENCH_MAX_MS = 9'h12C;
   localparam logic [8:0] QUENCH_DEF_MS = 9'h096;
   localparam logic ARC_EN_DEF = 1'b1;
   localparam logic NO_RERAMP_DEF = 1'b0;
   localparam logic PWRUP_REMOTE_DEF = 1'b0;
   // ==========================================================
   // Timing: one millisecond tick from the 100 MHz clock
   localparam int CLK_PERIOD_NS = 10;
   localparam int TICK_MS_NS = 1000000;
   localparam int TICK_CYCLES = TICK_MS_NS / CLK_PERIOD_NS;
   localparam int MS_PER_S = 1000;
   // Built-in re-ramp length in milliseconds
   localparam logic [15:0] STD_RAMP_MS = 16'h03E8;
endpackage

//--- afs_tick_gen.sv
module afs_tick_gen
   import afs_pkg::*;
#(
   parameter int CYCLES = TICK_CYCLES
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   output logic tick
);
   // ==========================================================
   // State
   typedef struct packed {
      logic [23:0] cnt;
      logic tick;
   } afs_tick_st_t;

   afs_tick_st_t s_q;
   afs_tick_st_t s_d;

   // Divider: one-cycle pulse every CYCLES clocks
   always_comb begin
      s_d = s_q;
      s_d.tick = 1'b0;
      if (s_q.cnt == 24'(CYCLES - 1)) begin
         s_d.cnt = 24'h000000;
         s_d.tick = 1'b1;
      end else begin
         s_d.cnt = s_q.cnt + 24'h000001;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign tick = s_q.tick;
endmodule

//--- afs_sync.sv
module afs_sync #(
   parameter int W = 1
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   // ==========================================================
   // Two-stage synchroniser; first stage read only by the second
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } afs_sync_st_t;

   afs_sync_st_t s_q;
   afs_sync_st_t s_d;

   always_comb begin
      s_d.s1 = din;
      s_d.s2 = s_q.s1;
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign dout = s_q.s2;
endmodule

//--- afs_supervisor.sv
module afs_supervisor
   import afs_pkg::*;
#(
   parameter int TICK_CYC = TICK_CYCLES
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic enable_contact,
   input wire logic arc_detect,
   input wire logic cmd_remote_mode,
   input wire logic cmd_local_mode,
   input wire logic cmd_hv_on,
   input wire logic cmd_hv_off,
   input wire logic cmd_clear,
   input wire logic cmd_save,
   input wire logic cmd_set_arc,
   input wire logic cfg_arc_en,
   input wire logic [3:0] cfg_arc_count,
   input wire logic [4:0] cfg_arc_period_s,
   input wire logic [8:0] cfg_quench_ms,
   input wire logic cfg_no_reramp,
   input wire logic cfg_pwrup_remote,
   input wire logic cfg_ramp_ctrl_en,
   input wire logic [15:0] cfg_user_ramp_ms,
   input wire logic nv_valid,
   input wire logic nv_arc_en,
   input wire logic [3:0] nv_arc_count,
   input wire logic [4:0] nv_arc_period_s,
   input wire logic [8:0] nv_quench_ms,
   input wire logic nv_no_reramp,
   input wire logic nv_pwrup_remote,
   input wire logic [15:0] sp_kv,
   input wire logic [15:0] sp_ma,
   input wire logic [15:0] sp_fil_lim,
   input wire logic [15:0] sp_preheat,
   input wire logic cmd_set_sp,
   output logic hv_on,
   output logic [15:0] kv_scale,
   output logic ramping,
   output logic remote_mode,
   output logic ps_fault,
   output logic arc_shutdown,
   output logic [3:0] arc_cnt_now,
   output logic nv_write,
   output logic [3:0] st_arc_count,
   output logic [4:0] st_arc_period_s,
   output logic [8:0] st_quench_ms,
   output logic st_arc_en,
   output logic st_no_reramp,
   output logic st_pwrup_remote,
   output logic [15:0] rsp_kv,
   output logic [15:0] rsp_ma,
   output logic [15:0] rsp_fil_lim,
   output logic [15:0] rsp_preheat
);
   // ==========================================================
   // Types
   typedef enum logic [3:0] {
      ST_OFF = 4'h1,
      ST_ON = 4'h2,
      ST_QUENCH = 4'h4,
      ST_RAMP = 4'h8
   } afs_out_t;

   typedef struct packed {
      afs_out_t st;
      logic boot;
      logic remote;
      logic fault;
      logic arc_sd;
      logic contact_prev;
      logic arc_prev;
      logic hv_on;
      logic ramping;
      logic hv_req;
      logic [3:0] arc_cnt;
      logic [14:0] win_ms;
      logic [8:0] q_ms;
      logic [15:0] r_ms;
      logic [15:0] r_len;
      logic [15:0] kv_scale;
      logic nv_write;
      logic [3:0] c_count;
      logic [4:0] c_period;
      logic [8:0] c_quench;
      logic c_arc_en;
      logic c_no_reramp;
      logic c_pwrup_remote;
      logic [15:0] sp_kv;
      logic [15:0] sp_ma;
      logic [15:0] sp_fil;
      logic [15:0] sp_pre;
   } afs_st_t;

   afs_st_t s_q;
   afs_st_t s_d;
   logic tick_ms;
   logic [1:0] pin_sync;
   logic contact;
   logic arc_in;
   logic arc_ev;
   logic [14:0] win_len;
   logic want_on;
   logic mode_trip;
   logic [15:0] ramp_len;

   // ==========================================================
   // Millisecond tick and pin synchronisers
   afs_tick_gen #(.CYCLES(TICK_CYC)) u_tick (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .tick(tick_ms)
   );

   afs_sync #(.W(2)) u_sync (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .din({enable_contact, arc_detect}),
      .dout(pin_sync)
   );

   assign contact = pin_sync[1];
   assign arc_in = pin_sync[0];

   // Arc edge on the synchronised level; idle low after reset, so no false edge
   assign arc_ev = arc_in & ~s_q.arc_prev;
   // Period in ms; 20 s fits in 15 bits
   assign win_len = 15'(s_q.c_period * MS_PER_S);

   // Local follows the contact; remote needs both request and contact
   always_comb begin
      if (s_q.remote) begin
         want_on = s_q.hv_req & contact;
      end else begin
         want_on = contact;
      end
   end

   // Remote switch while live; must win over the output state machine
   assign mode_trip = cmd_remote_mode && !s_q.remote && (s_q.st != ST_OFF);
   // Ramp length picked when a ramp starts
   assign ramp_len = s_q.c_no_reramp ? 16'h0000
      : (cfg_ramp_ctrl_en ? cfg_user_ramp_ms : STD_RAMP_MS);

   // ==========================================================
   // Next-state logic
   always_comb begin
      s_d = s_q;
      s_d.nv_write = 1'b0;
      s_d.contact_prev = contact;
      s_d.arc_prev = arc_in;

      // Power-up: take saved settings, else the defaults
      if (s_q.boot) begin
         s_d.boot = 1'b0;
         if (nv_valid) begin
            s_d.c_arc_en = nv_arc_en;
            s_d.c_count = nv_arc_count;
            s_d.c_period = nv_arc_period_s;
            s_d.c_quench = nv_quench_ms;
            s_d.c_no_reramp = nv_no_reramp;
            s_d.c_pwrup_remote = nv_pwrup_remote;
            s_d.remote = nv_pwrup_remote;
         end
      end

      // Settings checked against their ranges before use
      if (cmd_set_arc) begin
         s_d.c_arc_en = cfg_arc_en;
         s_d.c_no_reramp = cfg_no_reramp;
         s_d.c_pwrup_remote = cfg_pwrup_remote;
         if (cfg_arc_count >= ARC_CNT_MIN && cfg_arc_count <= ARC_CNT_MAX) begin
            s_d.c_count = cfg_arc_count;
         end
         if (cfg_arc_period_s >= ARC_PER_MIN_S && cfg_arc_period_s <= ARC_PER_MAX_S) begin
            s_d.c_period = cfg_arc_period_s;
         end
         if (cfg_quench_ms >= QUENCH_MIN_MS && cfg_quench_ms <= QUENCH_MAX_MS) begin
            s_d.c_quench = cfg_quench_ms;
         end
      end
      // Store written only on explicit request
      if (cmd_save) begin
         s_d.nv_write = 1'b1;
      end

      // Set points taken only while remote
      if (cmd_set_sp && s_q.remote) begin
         s_d.sp_kv = sp_kv;
         s_d.sp_ma = sp_ma;
         s_d.sp_fil = sp_fil_lim;
         s_d.sp_pre = sp_preheat;
      end

      // Remote enable requests; refused without contact
      if (cmd_hv_off || !contact) begin
         s_d.hv_req = 1'b0;
      end else if (cmd_hv_on && s_q.remote) begin
         s_d.hv_req = 1'b1;
      end

      // Mode change; live local output trips the fault
      if (cmd_remote_mode && !s_q.remote) begin
         s_d.remote = 1'b1;
         s_d.hv_req = 1'b0;
      end else if (cmd_local_mode && s_q.remote) begin
         s_d.remote = 1'b0;
         s_d.hv_req = 1'b0;
      end

      // Clear releases fault and arc latch
      if (cmd_clear) begin
         s_d.fault = 1'b0;
         s_d.arc_sd = 1'b0;
      end
      // Contact opened: an enable cycle also clears the latch
      if (s_q.contact_prev && !contact) begin
         s_d.arc_sd = 1'b0;
      end
      // Set beats clear for the fault in the same cycle
      if (mode_trip) begin
         s_d.fault = 1'b1;
      end

      // Observation window restarts at first arc
      if (s_q.arc_cnt != 4'h0 && tick_ms) begin
         if (s_q.win_ms + 15'h0001 >= win_len) begin
            s_d.arc_cnt = 4'h0;
            s_d.win_ms = 15'h0000;
         end else begin
            s_d.win_ms = s_q.win_ms + 15'h0001;
         end
      end

      unique case (s_q.st)
         ST_OFF: begin
            s_d.kv_scale = 16'h0000;
            if (want_on && !s_q.fault && !s_q.arc_sd && !s_d.fault) begin
               s_d.st = ST_RAMP;
               s_d.r_ms = 16'h0000;
               s_d.r_len = ramp_len;
            end
         end
         ST_ON, ST_RAMP: begin
            if (!want_on) begin
               s_d.st = ST_OFF;
               s_d.kv_scale = 16'h0000;
            end else if (arc_ev && s_q.c_arc_en) begin
               // Each arc blanks output and counts
               s_d.st = ST_QUENCH;
               s_d.kv_scale = 16'h0000;
               s_d.q_ms = 9'h000;
               if (s_q.arc_cnt == 4'h0) begin
                  s_d.win_ms = 15'h0000;
               end
               s_d.arc_cnt = s_q.arc_cnt + 4'h1;
               if (s_q.arc_cnt + 4'h1 >= s_q.c_count) begin
                  s_d.arc_sd = 1'b1;
                  s_d.st = ST_OFF;
                  s_d.arc_cnt = 4'h0;
               end
            end else if (s_q.st == ST_RAMP) begin
               // Linear ramp toward full set point scale
               if (s_q.r_ms >= s_q.r_len) begin
                  s_d.st = ST_ON;
                  s_d.kv_scale = 16'hFFFF;
               end else begin
                  s_d.kv_scale = 16'((32'(s_q.r_ms) * 32'h0000FFFF) / 32'(s_q.r_len));
                  if (tick_ms) begin
                     s_d.r_ms = s_q.r_ms + 16'h0001;
                  end
               end
            end else begin
               s_d.kv_scale = 16'hFFFF;
            end
         end
         ST_QUENCH: begin
            s_d.kv_scale = 16'h0000;
            if (!want_on) begin
               s_d.st = ST_OFF;
            end else if (tick_ms) begin
               if (s_q.q_ms + 9'h001 >= s_q.c_quench) begin
                  // Re-ramp profile chosen at quench end
                  s_d.st = ST_RAMP;
                  s_d.r_ms = 16'h0000;
                  s_d.r_len = ramp_len;
               end else begin
                  s_d.q_ms = s_q.q_ms + 9'h001;
               end
            end
         end
      endcase
      // Mode trip overrides a ramp, on or quench state decided above
      if (mode_trip) begin
         s_d.st = ST_OFF;
         s_d.kv_scale = 16'h0000;
      end
      // Output flags registered together with the state
      s_d.hv_on = (s_d.st == ST_ON) || (s_d.st == ST_RAMP);
      s_d.ramping = (s_d.st == ST_RAMP);
   end

   // ==========================================================
   // State register; defaults at reset
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
         s_q.st <= ST_OFF;
         s_q.boot <= 1'b1;
         s_q.remote <= PWRUP_REMOTE_DEF;
         s_q.c_arc_en <= ARC_EN_DEF;
         s_q.c_count <= ARC_CNT_DEF;
         s_q.c_period <= ARC_PER_DEF_S;
         s_q.c_quench <= QUENCH_DEF_MS;
         s_q.c_no_reramp <= NO_RERAMP_DEF;
         s_q.c_pwrup_remote <= PWRUP_REMOTE_DEF;
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs straight from the state register
   assign hv_on = s_q.hv_on;
   assign kv_scale = s_q.kv_scale;
   assign ramping = s_q.ramping;
   assign remote_mode = s_q.remote;
   assign ps_fault = s_q.fault;
   assign arc_shutdown = s_q.arc_sd;
   assign arc_cnt_now = s_q.arc_cnt;
   assign nv_write = s_q.nv_write;
   assign st_arc_count = s_q.c_count;
   assign st_arc_period_s = s_q.c_period;
   assign st_quench_ms = s_q.c_quench;
   assign st_arc_en = s_q.c_arc_en;
   assign st_no_reramp = s_q.c_no_reramp;
   assign st_pwrup_remote = s_q.c_pwrup_remote;
   assign rsp_kv = s_q.sp_kv;
   assign rsp_ma = s_q.sp_ma;
   assign rsp_fil_lim = s_q.sp_fil;
   assign rsp_preheat = s_q.sp_pre;

   // ==========================================================
   // Checks
   AST_ARC_BLANK: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (s_q.st == ST_QUENCH) |-> (kv_scale == 16'h0000 && !hv_on))
      else $error("output live during quench");
   AST_REMOTE_INTERLOCK: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (remote_mode && hv_on) |-> $past(contact))
      else $error("remote output on with open contact");
   AST_MODE_FAULT: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (cmd_remote_mode && !remote_mode && hv_on) |=> (ps_fault && !hv_on))
      else $error("mode switch while on did not fault");
   AST_CLEAR: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (cmd_clear && !mode_trip) |=> !ps_fault)
      else $error("clear did not drop fault");
   AST_SD_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_n)
      arc_shutdown |-> (s_q.st == ST_OFF))
      else $error("output live under arc shutdown");
   AST_SAVE: assert property (@(posedge ref_clk) disable iff (!rst_n)
      nv_write |-> $past(cmd_save))
      else $error("store written without save");
   AST_COUNT_RANGE: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (st_arc_count >= ARC_CNT_MIN && st_arc_count <= ARC_CNT_MAX))
      else $error("arc count out of range");
   AST_QUENCH_RANGE: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (st_quench_ms >= QUENCH_MIN_MS && st_quench_ms <= QUENCH_MAX_MS))
      else $error("quench out of range");
   AST_NORERAMP: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (s_q.st == ST_RAMP && s_q.r_len == 16'h0000 && want_on && !arc_ev)
      |=> (s_q.st == ST_ON))
      else $error("no-re-ramp still ramped");
   COV_ARC: cover property (@(posedge ref_clk) s_q.st == ST_QUENCH);
   COV_SD: cover property (@(posedge ref_clk) $rose(arc_shutdown));
   COV_FAULT: cover property (@(posedge ref_clk) $rose(ps_fault));
endmodule

//--- afs_host_model.sv
// ==========================================================
// Host and dry contact in front of the supervisor
module afs_host_model (
   input wire logic ref_clk,
   output logic enable_contact,
   output logic [7:0] cmd
);
   timeunit 1ns;
   timeprecision 1ps;

   // Contact open, no command until the bench asks
   initial begin
      enable_contact = 1'b0;
      cmd = 8'h00;
   end

   // Contact is a level; host keeps it until told otherwise
   task automatic set_contact(input logic v);
      @(negedge ref_clk);
      enable_contact = v;
   endtask

   // One-cycle command pulse, launched off the sampling edge
   task automatic send(input int i);
      @(negedge ref_clk);
      cmd[i] = 1'b1;
      @(negedge ref_clk);
      cmd[i] = 1'b0;
   endtask
endmodule

//--- afs_supervisor_bench.sv
module afs_supervisor_bench;
   import afs_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct packed {
      logic [3:0] cnt;
      logic [4:0] per;
      logic [8:0] q;
      logic [3:0] e_cnt;
      logic [4:0] e_per;
      logic [8:0] e_q;
   } afs_row_t;

   // Command bit positions on the host model
   localparam int C_REM = 0, C_LOC = 1, C_ON = 2, C_OFF = 3, C_CLR = 4, C_SAVE = 5;
   localparam int C_ARC = 6, C_SP = 7;
   // Tick shortened so a millisecond is two clocks
   localparam int TICK = 2;

   logic ref_clk, rst_n = 1'b0, arc_detect = 1'b0, enable_contact;
   logic [7:0] cmd;
   logic cfg_arc_en = 1'b1, cfg_no_reramp = 1'b0, cfg_pwrup_remote = 1'b0;
   logic [3:0] cfg_arc_count = 4'h4;
   logic [4:0] cfg_arc_period_s = 5'h0A;
   logic [8:0] cfg_quench_ms = 9'h096;
   logic cfg_ramp_ctrl_en = 1'b0;
   logic [15:0] cfg_user_ramp_ms = 16'h000A;
   logic nv_valid = 1'b0, nv_arc_en = 1'b1, nv_no_reramp = 1'b0, nv_pwrup_remote = 1'b0;
   logic [3:0] nv_arc_count = 4'h3;
   logic [4:0] nv_arc_period_s = 5'h0F;
   logic [8:0] nv_quench_ms = 9'h0C8;
   logic [15:0] sp_kv = 16'h0000, sp_ma = 16'h0000, sp_fil_lim = 16'h0A0A, sp_preheat = 16'h0505;
   logic hv_on, ramping, remote_mode, ps_fault, arc_shutdown, nv_write, st_arc_en, st_no_reramp;
   logic st_pwrup_remote;
   logic [15:0] kv_scale, rsp_kv, rsp_ma, rsp_fil_lim, rsp_preheat;
   logic [3:0] st_arc_count, arc_cnt_now;
   logic [4:0] st_arc_period_s;
   logic [8:0] st_quench_ms;
   int n_fail = 0;
   int checks_done = 0;
   afs_row_t rows [5] = '{
      {4'h2, 5'h0A, 9'h032, 4'h2, 5'h0A, 9'h032},
      {4'hA, 5'h14, 9'h12C, 4'hA, 5'h14, 9'h12C},
      {4'h1, 5'h09, 9'h031, 4'hA, 5'h14, 9'h12C},
      {4'hB, 5'h15, 9'h12D, 4'hA, 5'h14, 9'h12C},
      {4'h4, 5'h0A, 9'h096, 4'h4, 5'h0A, 9'h096}};

   afs_host_model host_i (.ref_clk(ref_clk), .enable_contact(enable_contact), .cmd(cmd));

   afs_supervisor #(.TICK_CYC(TICK)) afs_supervisor_i (
      .ref_clk(ref_clk), .rst_n(rst_n), .enable_contact(enable_contact), .arc_detect(arc_detect),
      .cmd_remote_mode(cmd[0]), .cmd_local_mode(cmd[1]), .cmd_hv_on(cmd[2]), .cmd_hv_off(cmd[3]),
      .cmd_clear(cmd[4]), .cmd_save(cmd[5]), .cmd_set_arc(cmd[6]), .cmd_set_sp(cmd[7]),
      .cfg_arc_en(cfg_arc_en), .cfg_arc_count(cfg_arc_count), .cfg_arc_period_s(cfg_arc_period_s),
      .cfg_quench_ms(cfg_quench_ms), .cfg_no_reramp(cfg_no_reramp),
      .cfg_pwrup_remote(cfg_pwrup_remote), .cfg_ramp_ctrl_en(cfg_ramp_ctrl_en),
      .cfg_user_ramp_ms(cfg_user_ramp_ms), .nv_valid(nv_valid), .nv_arc_en(nv_arc_en),
      .nv_arc_count(nv_arc_count), .nv_arc_period_s(nv_arc_period_s),
      .nv_quench_ms(nv_quench_ms), .nv_no_reramp(nv_no_reramp),
      .nv_pwrup_remote(nv_pwrup_remote), .sp_kv(sp_kv), .sp_ma(sp_ma), .sp_fil_lim(sp_fil_lim),
      .sp_preheat(sp_preheat), .hv_on(hv_on), .kv_scale(kv_scale), .ramping(ramping),
      .remote_mode(remote_mode), .ps_fault(ps_fault), .arc_shutdown(arc_shutdown),
      .arc_cnt_now(arc_cnt_now), .nv_write(nv_write), .st_arc_count(st_arc_count),
      .st_arc_period_s(st_arc_period_s), .st_quench_ms(st_quench_ms), .st_arc_en(st_arc_en),
      .st_no_reramp(st_no_reramp), .st_pwrup_remote(st_pwrup_remote),
      .rsp_kv(rsp_kv), .rsp_ma(rsp_ma),
      .rsp_fil_lim(rsp_fil_lim), .rsp_preheat(rsp_preheat)
   );

   // ==========================================================
   // Clock, helpers, verdict
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic step(input int n);
      repeat (n) @(negedge ref_clk);
   endtask

   // Reset held four clocks, then two edges for the saved settings load
   task automatic apply_reset();
      @(negedge ref_clk);
      rst_n = 1'b0;
      step(4);
      rst_n = 1'b1;
      step(2);
   endtask

   // Single rising edge on the arc pin, held past the synchroniser
   task automatic pulse_arc();
      @(negedge ref_clk);
      arc_detect = 1'b1;
      step(3);
      arc_detect = 1'b0;
   endtask

   // Bounded wait; the ramp must finish, so no open-ended loop
   task automatic wait_full(input int lim);
      for (int k = 0; k < lim && kv_scale !== 16'hFFFF; k++) @(negedge ref_clk);
   endtask

   task automatic close_out();
      $display("Checks made %0d, mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Whole run is well under 15000 clocks
   initial begin
      repeat (40000) @(posedge ref_clk);
      n_fail++;
      close_out();
   end

   // ==========================================================
   // Tests
   initial begin
      apply_reset();
      check(st_arc_en, 1'b1);
      check(st_arc_count, 4'h4);
      check(st_arc_period_s, 5'h0A);
      check(st_quench_ms, 9'h096);
      check(st_no_reramp, 1'b0);
      check(remote_mode, 1'b0);
      check(st_pwrup_remote, 1'b0);
      $display("defaults done");
      // Range table: out-of-range fields keep the last good value
      foreach (rows[i]) begin
         cfg_arc_count = rows[i].cnt;
         cfg_arc_period_s = rows[i].per;
         cfg_quench_ms = rows[i].q;
         host_i.send(C_ARC);
         check(st_arc_count, rows[i].e_cnt);
         check(st_arc_period_s, rows[i].e_per);
         check(st_quench_ms, rows[i].e_q);
         check(nv_write, 1'b0);
      end
      host_i.send(C_SAVE);
      for (int k = 0; k < 4 && nv_write !== 1'b1; k++) @(negedge ref_clk);
      check(nv_write, 1'b1);
      step(1);
      check(nv_write, 1'b0);
      $display("settings done");
      // Quench, standard re-ramp, user ramp, no re-ramp
      host_i.set_contact(1'b1);
      wait_full(2600);
      check(kv_scale, 16'hFFFF);
      pulse_arc();
      step(8);
      check(kv_scale, 16'h0000);
      check(arc_cnt_now, 4'h1);
      step(250);
      check(kv_scale, 16'h0000);
      step(60);
      check(ramping, 1'b1);
      cfg_ramp_ctrl_en = 1'b1;
      pulse_arc();
      step(340);
      check(kv_scale, 16'hFFFF);
      cfg_ramp_ctrl_en = 1'b0;
      cfg_no_reramp = 1'b1;
      host_i.send(C_ARC);
      pulse_arc();
      step(320);
      check(kv_scale, 16'hFFFF);
      check(ramping, 1'b0);
      $display("quench done");
      // Arc count reached on the second arc, latched until clear
      cfg_no_reramp = 1'b0;
      apply_reset();
      cfg_arc_count = 4'h2;
      host_i.send(C_ARC);
      step(6);
      pulse_arc();
      step(8);
      check(arc_shutdown, 1'b0);
      step(320);
      pulse_arc();
      step(8);
      check(arc_shutdown, 1'b1);
      check(hv_on, 1'b0);
      check(arc_cnt_now, 4'h0);
      step(400);
      check(arc_shutdown, 1'b1);
      host_i.send(C_CLR);
      step(2);
      check(arc_shutdown, 1'b0);
      host_i.set_contact(1'b0);
      step(5);
      check(hv_on, 1'b0);
      $display("arc count done");
      // Mode change while on, interlock, remote set points
      apply_reset();
      host_i.set_contact(1'b1);
      step(6);
      check(hv_on, 1'b1);
      host_i.send(C_REM);
      check(kv_scale, 16'h0000);
      step(2);
      check(remote_mode, 1'b1);
      check(hv_on, 1'b0);
      check(ps_fault, 1'b1);
      host_i.send(C_CLR);
      step(2);
      check(ps_fault, 1'b0);
      host_i.set_contact(1'b0);
      step(5);
      host_i.send(C_ON);
      step(4);
      check(hv_on, 1'b0);
      sp_kv = 16'h1234;
      sp_ma = 16'h0456;
      host_i.send(C_SP);
      check(rsp_kv, 16'h1234);
      check(rsp_ma, 16'h0456);
      check(rsp_fil_lim, 16'h0A0A);
      check(rsp_preheat, 16'h0505);
      host_i.set_contact(1'b1);
      step(5);
      host_i.send(C_ON);
      step(4);
      check(hv_on, 1'b1);
      host_i.send(C_OFF);
      step(4);
      check(hv_on, 1'b0);
      host_i.send(C_LOC);
      sp_kv = 16'h5678;
      host_i.send(C_SP);
      check(rsp_kv, 16'h1234);
      // Arc control off: an arc neither blanks nor counts
      cfg_arc_en = 1'b0;
      host_i.send(C_ARC);
      pulse_arc();
      step(8);
      check(hv_on, 1'b1);
      check(arc_cnt_now, 4'h0);
      $display("remote done");
      // Saved power-up remote with the contact already closed
      nv_valid = 1'b1;
      nv_pwrup_remote = 1'b1;
      apply_reset();
      step(6);
      check(remote_mode, 1'b1);
      check(hv_on, 1'b0);
      check(st_arc_count, 4'h3);
      check(st_quench_ms, 9'h0C8);
      check(st_arc_period_s, 5'h0F);
      check(st_pwrup_remote, 1'b1);
      $display("power-up done");
      close_out();
   end
endmodule
